// ---- src/csfs_clock_select.sv ----
// Clock source selection, input supervision, mirroring and MADI redundancy
//
// Overview of operation
// - Mirroring on: MADI outputs 2 and 3 carry exactly port 1's stream.
// - Mirroring on: playback channel count drops to 2+2+64.
// - Redundancy on: only 66 input channels, AES plus one MADI.
// - Redundancy: other two MADI inputs stand by, taken when active fails.
// - Clock source is internal master or word, MADI, AES or sync input.
// - Configured source without lock: take next input with a valid signal.
// - No valid input anywhere: run from internal oscillator as master.
// - Source actually in use is readable apart from the preferred one.
// - Each input reports no lock, lock, or lock and synchronous.
// - Each input reports a coarse incoming sample rate.
// - Each MADI input reports 48K or 96K frame.
// - Each MADI input reports 64 or 56 channels.
// - Automatic mode watches inputs, leaves internal once one is valid.
// - Reference fails with no other valid input: fall back to internal oscillator as master.
// - Keep preferred input while it carries a valid signal.
// - Preferred input invalid: examine remaining inputs one after another.
// - Sample rate setting defines the internally generated rate.
// - Redundancy switchover completes within less than one sample.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module csfs_clock_select
    import csfs_pkg::*;
#(
    parameter int DW = 32,
    parameter int WIN_CYC = RATE_WIN_CYC
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [NSRC-1:0] SRC_VALID,
    input wire logic [NSRC-1:0] SRC_SYNC,
    input wire logic [NSRC-1:0] SRC_FRAME_TICK,
    input wire logic [NMADI-1:0] MADI_FRAME96,
    input wire logic [NMADI-1:0] MADI_CH56,
    input wire logic [NMADI*DW-1:0] MADI_TX_SRC,
    input wire logic [NMADI*DW-1:0] MADI_RX_DATA,
    output logic [NMADI*DW-1:0] MADI_TX_DATA,
    output logic [DW-1:0] MADI_RX_ACTIVE,
    output logic [1:0] ACTIVE_MADI_PORT,
    output logic [2:0] CUR_SOURCE,
    output logic CLOCK_MASTER,
    output logic INT_FS_TICK,
    output logic [7:0] PLAY_CHANNELS,
    output logic [7:0] REC_CHANNELS
);
    localparam int WW = $clog2(WIN_CYC + 1);

    typedef struct packed {
        csfs_src_t pref;
        logic mirror;
        logic redund;
        logic [3:0] rate_sel;
        csfs_src_t cur;
        logic [1:0] port;
        logic ack;
        logic [31:0] rdata;
        logic [11:0] div_cnt;
        logic fs_tick;
        logic [WW-1:0] win_cnt;
        logic [2*NSRC-1:0] lock;
        logic [NMADI-1:0] f96;
        logic [NMADI-1:0] ch56;
        logic [7:0] play;
        logic [7:0] rec;
        logic [NMADI*DW-1:0] tx;
        logic [DW-1:0] rx;
    } csfs_state_t;

    csfs_state_t st;
    csfs_state_t next_st;

    logic win;
    logic [4*NSRC-1:0] rates;

    // First set bit of ok[n-1:0] at or after start, cyclically
    function automatic logic [3:0] scan_from(input logic [NSRC-1:0] ok,
                                             input int start, input int n);
        logic [3:0] r;
        int j;
        r = 4'h0;
        for (int k = n - 1; k >= 0; k--) begin
            j = (start + k) % n;
            if (ok[j]) begin
                r = {1'b1, 3'(j)};
            end
        end
        return r;
    endfunction

    assign win = (st.win_cnt == WW'(WIN_CYC - 1));

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_meter
            csfs_meter_if mif ();
            assign mif.win = win;
            assign mif.tick = SRC_FRAME_TICK[gi];
            assign rates[4*gi +: 4] = mif.code;
            csfs_rate_meter u_meter (
                .clk (REF_CLK),
                .rst (SYS_RST),
                .m (mif)
            );
        end
    endgenerate

    logic [3:0] scan;
    logic [3:0] mscan;
    logic [2:0] pidx;
    logic [1:0] sel_port;
    logic req;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;

    always_comb begin
        next_st = st;
        req = AVS_READ || AVS_WRITE;
        wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                 {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_PREF_LSB +: 3] = st.pref;
        ctrl_word[CTRL_MIRROR_BIT] = st.mirror;
        ctrl_word[CTRL_REDUND_BIT] = st.redund;
        ctrl_word[CTRL_RATE_LSB +: 4] = st.rate_sel;

        // Clock source decision, one pass per cycle
        pidx = 3'(st.pref) - 3'h1;
        scan = scan_from(SRC_VALID, int'(pidx) + 1, NSRC);
        if (st.pref == CSFS_INTERNAL) begin
            next_st.cur = CSFS_INTERNAL;
        end else if (SRC_VALID[pidx]) begin
            next_st.cur = st.pref;
        end else if (scan[3]) begin
            next_st.cur = csfs_src_t'(scan[2:0] + 3'h1);
        end else begin
            next_st.cur = CSFS_INTERNAL;
        end

        // Switch the port register on the first edge after the active input drops
        mscan = scan_from({3'b000, SRC_VALID[3:1]}, int'(st.port) + 1, NMADI);
        sel_port = st.port;
        if (st.redund && !SRC_VALID[3'(st.port) + 3'h1] && mscan[3]) begin
            sel_port = mscan[1:0];
        end
        next_st.port = st.redund ? sel_port : 2'h0;
        // Mux follows next_st.port, the port being registered, so data and port number agree
        next_st.rx = MADI_RX_DATA[DW*next_st.port +: DW];

        for (int i = 0; i < NMADI; i++) begin
            next_st.tx[DW*i +: DW] = (st.mirror && i > 0) ?
                MADI_TX_SRC[DW-1:0] : MADI_TX_SRC[DW*i +: DW];
        end
        next_st.play = st.mirror ? PLAY_MIRROR : PLAY_FULL;
        next_st.rec = st.redund ? REC_REDUND : REC_FULL;

        for (int i = 0; i < NSRC; i++) begin
            if (!SRC_VALID[i]) begin
                next_st.lock[2*i +: 2] = CSFS_NO_LOCK;
            end else if (SRC_SYNC[i]) begin
                next_st.lock[2*i +: 2] = CSFS_SYNCED;
            end else begin
                next_st.lock[2*i +: 2] = CSFS_LOCKED;
            end
        end
        next_st.f96 = MADI_FRAME96;
        next_st.ch56 = MADI_CH56;

        // Internal sample clock enable from the selected rate
        next_st.fs_tick = 1'b0;
        if (st.div_cnt >= fs_div(st.rate_sel) - 12'h001) begin
            next_st.div_cnt = 12'h000;
            next_st.fs_tick = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + 12'h001;
        end
        next_st.win_cnt = win ? '0 : st.win_cnt + WW'(1);

        // Avalon slave: one wait cycle, answer on the second edge
        next_st.ack = req && !st.ack;
        if (req && !st.ack && AVS_READ) begin
            next_st.rdata = 32'h0000_0000;
            unique case (AVS_ADDRESS)
                OFS_CTRL: begin
                    next_st.rdata = ctrl_word;
                end
                OFS_STATUS: begin
                    next_st.rdata[STAT_CUR_LSB +: 3] = st.cur;
                    next_st.rdata[STAT_MASTER_BIT] = (st.cur == CSFS_INTERNAL);
                    next_st.rdata[STAT_PORT_LSB +: 2] = st.port;
                end
                OFS_CHANS: begin
                    next_st.rdata[CHANS_PLAY_LSB +: 8] = st.play;
                    next_st.rdata[CHANS_REC_LSB +: 8] = st.rec;
                end
                OFS_LOCK: begin
                    next_st.rdata[2*NSRC-1:0] = st.lock;
                end
                OFS_RATE: begin
                    next_st.rdata[4*NSRC-1:0] = rates;
                end
                OFS_MADIFMT: begin
                    next_st.rdata[FMT_F96_LSB +: NMADI] = st.f96;
                    next_st.rdata[FMT_CH56_LSB +: NMADI] = st.ch56;
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (st.ack && AVS_WRITE && AVS_ADDRESS == OFS_CTRL) begin
            ctrl_word = (ctrl_word & ~wmask) | (AVS_WRITEDATA & wmask);
            // Code 7 is not a source; treat it as internal
            next_st.pref = (ctrl_word[CTRL_PREF_LSB +: 3] == 3'h7) ? CSFS_INTERNAL :
                csfs_src_t'(ctrl_word[CTRL_PREF_LSB +: 3]);
            next_st.mirror = ctrl_word[CTRL_MIRROR_BIT];
            next_st.redund = ctrl_word[CTRL_REDUND_BIT];
            next_st.rate_sel = ctrl_word[CTRL_RATE_LSB +: 4];
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st <= '0;
            st.rate_sel <= RST_RATE_SEL;
            st.play <= PLAY_FULL;
            st.rec <= REC_FULL;
        end else begin
            st <= next_st;
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !st.ack;
    assign AVS_READDATA = st.rdata;
    assign MADI_TX_DATA = st.tx;
    assign MADI_RX_ACTIVE = st.rx;
    assign ACTIVE_MADI_PORT = st.port;
    assign CUR_SOURCE = st.cur;
    assign CLOCK_MASTER = (st.cur == CSFS_INTERNAL);
    assign INT_FS_TICK = st.fs_tick;
    assign PLAY_CHANNELS = st.play;
    assign REC_CHANNELS = st.rec;
endmodule

// ---- common/csfs_pkg.sv ----
// Package: constants, types and helpers for the clock source fallback selector
package csfs_pkg;
    localparam int NSRC = 6;
    localparam int NMADI = 3;
    localparam int CLK_MHZ = 100;
    localparam int RATE_WIN_US = 1000;
    localparam int RATE_WIN_CYC = RATE_WIN_US * CLK_MHZ;

    // Source 0 is the internal oscillator, inputs are numbered 1..6
    typedef enum logic [2:0] {
        CSFS_INTERNAL,
        CSFS_WORD,
        CSFS_MADI1,
        CSFS_MADI2,
        CSFS_MADI3,
        CSFS_AES,
        CSFS_SYNCIN
    } csfs_src_t;

    typedef enum logic [1:0] {
        CSFS_NO_LOCK,
        CSFS_LOCKED,
        CSFS_SYNCED
    } csfs_lock_t;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_CHANS = 5'h08;
    localparam logic [4:0] OFS_LOCK = 5'h0c;
    localparam logic [4:0] OFS_RATE = 5'h10;
    localparam logic [4:0] OFS_MADIFMT = 5'h14;

    localparam int CTRL_PREF_LSB = 0;
    localparam int CTRL_MIRROR_BIT = 4;
    localparam int CTRL_REDUND_BIT = 5;
    localparam int CTRL_RATE_LSB = 8;
    localparam int STAT_CUR_LSB = 0;
    localparam int STAT_MASTER_BIT = 3;
    localparam int STAT_PORT_LSB = 4;
    localparam int CHANS_PLAY_LSB = 0;
    localparam int CHANS_REC_LSB = 8;
    localparam int FMT_F96_LSB = 0;
    localparam int FMT_CH56_LSB = 4;

    localparam logic [3:0] RST_RATE_SEL = 4'h2;
    localparam logic [7:0] PLAY_FULL = 8'hc4;
    localparam logic [7:0] PLAY_MIRROR = 8'h44;
    localparam logic [7:0] REC_FULL = 8'hc2;
    localparam logic [7:0] REC_REDUND = 8'h42;

    // Internal sample rates, index is the rate selection code
    localparam int FS_HZ [9] = '{32000, 44100, 48000, 64000, 88200, 96000,
                                 128000, 176400, 192000};

    // Frame ticks per window, lower edge of each rate bucket
    localparam logic [8:0] RATE_EDGE [9] = '{9'h010, 9'h026, 9'h02e, 9'h038,
                                             9'h04c, 9'h05c, 9'h070, 9'h098,
                                             9'h0b8};

    // Cycles of REF_CLK per internal sample, rounded to nearest
    function automatic logic [11:0] fs_div(input logic [3:0] sel);
        int s;
        s = (sel > 4'h8) ? 8 : int'(sel);
        return 12'((CLK_MHZ * 1000000 + FS_HZ[s] / 2) / FS_HZ[s]);
    endfunction

    // 0 means no measurable rate, 1..9 follow FS_HZ order
    function automatic logic [3:0] rate_code(input logic [8:0] cnt);
        logic [3:0] c;
        c = 4'h0;
        for (int k = 0; k < 9; k++) begin
            if (cnt >= RATE_EDGE[k]) begin
                c = 4'(k + 1);
            end
        end
        return c;
    endfunction
endpackage

// ---- common/csfs_meter_if.sv ----
// Interface between the selector and one input rate meter
`timescale 1ns/1ps
interface csfs_meter_if;
    logic win;
    logic tick;
    logic [3:0] code;
    modport main (output win, output tick, input code);
    modport meter (input win, input tick, output code);
endinterface

// ---- src/csfs_rate_meter.sv ----
// Coarse sample rate meter for one clock-capable input
`timescale 1ns/1ps
module csfs_rate_meter
    import csfs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    csfs_meter_if.meter m
);
    typedef struct packed {
        logic [8:0] cnt;
        logic [3:0] code;
    } csfs_meter_t;

    csfs_meter_t st;
    csfs_meter_t next_st;

    always_comb begin
        next_st = st;
        if (m.win) begin
            next_st.code = rate_code(st.cnt);
            next_st.cnt = {8'h00, m.tick};
        end else if (m.tick && st.cnt != 9'h1ff) begin
            // Saturate so a runaway input cannot wrap to a low rate
            next_st.cnt = st.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign m.code = st.code;
endmodule

// ---- test/csfs_monitor.sv ----
// Port-level assertions for the clock source selector
`timescale 1ns/1ps
module csfs_monitor
    import csfs_pkg::*;
#(
    parameter int DW = 32
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic [NSRC-1:0] SRC_VALID,
    input wire logic [NMADI*DW-1:0] MADI_TX_SRC,
    input wire logic [NMADI*DW-1:0] MADI_RX_DATA,
    input wire logic [NMADI*DW-1:0] MADI_TX_DATA,
    input wire logic [DW-1:0] MADI_RX_ACTIVE,
    input wire logic [1:0] ACTIVE_MADI_PORT,
    input wire logic [2:0] CUR_SOURCE,
    input wire logic CLOCK_MASTER,
    input wire logic [7:0] PLAY_CHANNELS,
    input wire logic [7:0] REC_CHANNELS
);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    logic [NMADI*DW-1:0] tx_q;
    logic [NMADI*DW-1:0] rx_q;
    // One cycle copies of the streams, compared with registered outputs
    always_ff @(posedge REF_CLK) begin
        tx_q <= MADI_TX_SRC;
        rx_q <= MADI_RX_DATA;
    end
    sequence bus_waiting;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence bus_answered;
        !AVS_WAITREQUEST;
    endsequence
    one_wait_a: assert property (bus_waiting |=> bus_answered)
        else $error("bus answer late");
    master_flag_a: assert property (CLOCK_MASTER == (CUR_SOURCE == 3'h0))
        else $error("master flag wrong");
    ref_lost_a: assert property (CUR_SOURCE != 3'h0 && !SRC_VALID[CUR_SOURCE - 3'h1]
        |=> CUR_SOURCE != $past(CUR_SOURCE)) else $error("kept failed source");
    no_input_a: assert property (SRC_VALID == '0 |=> CUR_SOURCE == 3'h0)
        else $error("no fallback to internal");
    mirror_copy_a: assert property (!$past(SYS_RST) && PLAY_CHANNELS == PLAY_MIRROR
        && $past(PLAY_CHANNELS) == PLAY_MIRROR |-> MADI_TX_DATA == {3{tx_q[DW-1:0]}})
        else $error("mirror data wrong");
    rec_port_a: assert property (ACTIVE_MADI_PORT != 2'h0 |-> REC_CHANNELS == REC_REDUND)
        else $error("port set outside redundancy");
    port_switch_a: assert property (REC_CHANNELS == REC_REDUND
        && !SRC_VALID[ACTIVE_MADI_PORT + 1] && SRC_VALID[3:1] != 3'h0
        |=> ACTIVE_MADI_PORT != $past(ACTIVE_MADI_PORT)) else $error("no switchover");
    rx_follow_a: assert property (!$past(SYS_RST)
        |-> MADI_RX_ACTIVE == rx_q[ACTIVE_MADI_PORT*DW +: DW]) else $error("rx port data");
endmodule

// ---- test/csfs_far_end.sv ----
// Far-end audio equipment: signal presence, frames, received data
`timescale 1ns/1ps
module csfs_far_end
    import csfs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NSRC-1:0] present,
    input wire logic [NSRC-1:0] locked,
    output logic [NSRC-1:0] valid,
    output logic [NSRC-1:0] sync,
    output logic [NSRC-1:0] tick,
    output logic [NMADI-1:0] f96,
    output logic [NMADI-1:0] c56,
    output logic [NMADI*32-1:0] rx
);
    logic [15:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
    // Absent sources send no frames; word clock runs twice as fast
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            tick[i] = present[i] && (cnt % ((i == 0) ? 10 : 20) == 0);
        end
    end
    assign valid = present;
    assign sync = present & locked;
    assign f96 = 3'h5;
    assign c56 = 3'h2;
    // Data changes every cycle, so a stale word never matches
    assign rx = {~cnt, 16'h3333 ^ cnt, cnt, 16'h2222 ^ cnt, cnt, 16'h1111 ^ cnt};
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
module tb_top;
    import csfs_pkg::*;
    localparam logic [2:0] PF [9] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h5, 3'h6, 3'h6, 3'h0, 3'h3};
    localparam logic [5:0] PV [9] = '{6'h00, 6'h01, 6'h11, 6'h10, 6'h28, 6'h03, 6'h00, 6'h3f,
        6'h14};
    localparam logic [2:0] PC [9] = '{3'h0, 3'h1, 3'h1, 3'h5, 3'h6, 3'h1, 3'h0, 3'h0, 3'h3};
    localparam logic [5:0] RP [5] = '{6'h0c, 6'h08, 6'h02, 6'h00, 6'h04};
    localparam logic [1:0] RE [5] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h1};
    logic REF_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0] be = 4'hf;
    logic [5:0] present = 6'h00;
    logic [5:0] locked = 6'h00;
    logic [95:0] tx_src = 96'h0;
    logic [31:0] rdata, rx_act, got;
    logic [5:0] valid, sync, tick;
    logic [2:0] f96, c56, cur;
    logic [95:0] rx, tx_data;
    logic [95:0] rx_d;
    logic [1:0] port;
    logic wait_req, master, fs_tick;
    logic [7:0] play, rec;
    int fails = 0;
    int checks = 0;
    int n;
    always #5 REF_CLK = ~REF_CLK;
    // Port 1 differs from ports 2 and 3, so a mirror shows
    always @(posedge REF_CLK) begin
        tx_src <= {~tx_src[95:32], tx_src[31:0] + 32'h0000_0001};
        rx_d <= rx;
    end
    csfs_far_end csfs_far_end_i (.clk(REF_CLK), .rst(SYS_RST), .present(present),
        .locked(locked), .valid(valid), .sync(sync), .tick(tick), .f96(f96), .c56(c56), .rx(rx));
    csfs_clock_select #(.DW(32), .WIN_CYC(1000)) csfs_clock_select_i (.REF_CLK(REF_CLK),
        .SYS_RST(SYS_RST), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .SRC_VALID(valid), .SRC_SYNC(sync), .SRC_FRAME_TICK(tick),
        .MADI_FRAME96(f96), .MADI_CH56(c56), .MADI_TX_SRC(tx_src), .MADI_RX_DATA(rx),
        .MADI_TX_DATA(tx_data), .MADI_RX_ACTIVE(rx_act), .ACTIVE_MADI_PORT(port),
        .CUR_SOURCE(cur), .CLOCK_MASTER(master), .INT_FS_TICK(fs_tick),
        .PLAY_CHANNELS(play), .REC_CHANNELS(rec));
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Entered just after a rising edge; waitrequest and data are taken at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (wait_req !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk(32'(k), 32'h0000_0002, "bus answer");
        @(posedge REF_CLK);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0000_0000);
        chk(got, e, m);
    endtask
    function automatic logic [31:0] st(input logic [2:0] c, input logic [1:0] p);
        return {26'h000_0000, p, c == 3'h0, c};
    endfunction
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge REF_CLK);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        @(posedge REF_CLK);
        rchk(5'h00, 32'h0000_0200, "ctrl reset");
        rchk(5'h08, 32'h0000_c2c4, "chans reset");
        bus(1'b1, 5'h04, 32'h0000_0005);
        rchk(5'h04, st(3'h0, 2'h0), "status ro");
        rchk(5'h18, 32'h0000_0000, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            present <= PV[i];
            bus(1'b1, 5'h00, {20'h0_0000, 4'h2, 5'h00, PF[i]});
            rchk(5'h04, st(PC[i], 2'h0), "current source");
            chk(32'(cur), 32'(PC[i]), "source pin");
            chk(32'(master), 32'(PC[i] == 3'h0), "master pin");
        end
        $display("test fallback done");
        present <= 6'h03;
        locked <= 6'h01;
        // Two full meter windows so the rate codes settle
        repeat (2010) @(posedge REF_CLK);
        rchk(5'h0c, 32'h0000_0006, "lock state");
        rchk(5'h10, 32'h0000_0036, "rate code");
        rchk(5'h14, 32'h0000_0025, "madi format");
        chk(got >> 4, 32'h0000_0002, "channel format");
        $display("test input status done");
        be <= 4'h1;
        bus(1'b1, 5'h00, 32'h0000_0f37);
        be <= 4'hf;
        present <= 6'h0e;
        rchk(5'h00, 32'h0000_0230, "ctrl lanes");
        rchk(5'h08, 32'h0000_4244, "reduced chans");
        @(negedge REF_CLK);
        chk(tx_data[95:64], tx_src[31:0] - 32'h0000_0001, "mirror port 3");
        chk(tx_data[63:32], tx_src[31:0] - 32'h0000_0001, "mirror port 2");
        @(posedge REF_CLK);
        for (int i = 0; i < 5; i++) begin
            present <= RP[i];
            @(posedge REF_CLK);
            rchk(5'h04, st(3'h0, RE[i]), "active port");
            chk(rx_act, rx_d[32*RE[i] +: 32], "rx port data");
        end
        bus(1'b1, 5'h00, 32'h0000_0200);
        rchk(5'h08, 32'h0000_c2c4, "full chans");
        $display("test redundancy done");
        for (int s = 0; s < 9; s++) begin
            bus(1'b1, 5'h00, 32'(s) << 8);
            repeat (3) begin
                n = 0;
                do begin
                    @(negedge REF_CLK);
                    n++;
                end while (fs_tick !== 1'b1 && n < 4000);
            end
            chk(32'(n), 32'((32'h05f5_e100 + FS_HZ[s] / 2) / FS_HZ[s]), "fs period");
            @(posedge REF_CLK);
        end
        $display("test internal rate done");
        wrap_up();
    end
endmodule
bind csfs_clock_select csfs_monitor #(.DW(DW)) csfs_monitor_i (.REF_CLK, .SYS_RST, .AVS_READ,
    .AVS_WRITE, .AVS_WAITREQUEST, .SRC_VALID, .MADI_TX_SRC, .MADI_RX_DATA, .MADI_TX_DATA,
    .MADI_RX_ACTIVE, .ACTIVE_MADI_PORT, .CUR_SOURCE, .CLOCK_MASTER, .PLAY_CHANNELS,
    .REC_CHANNELS);
